//--- prr_sequencer.sv
`timescale 1ns/1ps
`include "prr_consts.svh"

// Functional notes
// - erase of phrase zero zeroes entries 1..63 and writes initial control data
// - erase-all also clears user data of all 64 entries
// - single erase zeroes the entry and returns its blocks to phrase zero
// - flexible record ends on block count or no free blocks, flag clears
// - stop in flexible record saves block counter and address counter
// - flexible output_select_cmd start reads start and stop address from the index entry first
// - playback ends when address counter equals stop address, flag clears
// - direct start loads counter and stop register from the index entry
// - direct recording ends when address counter equals stop address
// - stop in direct record writes address counter as new stop address
// - threshold ignored during playback, only width applies
// - ROM mode uses phrases 1..255 and ignores the rate setting
// - ROM start reads start, stop, rate and width from the ROM index
// - gain 00/01 is 0 dB, 10 is -6 dB, 11 is -12 dB, reset gives 0 dB
// - active flag reads 1 while waiting and throughout recording
module prr_sequencer
   import prr_pkg::*;
#(
   parameter int BLK_SHIFT = 8
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    sample_tick,
   output logic [`PRR_ADDR_W-1:0]       mem_addr,
   output logic                         mem_record,
   output logic                         mem_output_select_cmd,
   output logic                         active_operation_flag,
   output logic [1:0]                   gain_shift,
   output logic                         sample_width,
   output logic [1:0]                   rate_sel,
   output logic [1:0]                   activation_threshold,
   output logic                         rom_idx_req,
   output logic [7:0]                   rom_idx_phrase,
   input  wire logic                    rom_idx_valid,
   input  wire logic [`PRR_ADDR_W-1:0]  rom_idx_start,
   input  wire logic [`PRR_ADDR_W-1:0]  rom_idx_stop,
   input  wire logic [1:0]              rom_idx_rate,
   input  wire logic                    rom_idx_width
);

   prr_idx_if idx_bus ();

   prr_index_store u_store (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (idx_bus.store)
   );

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic                   aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0]             awa_q, awa_d;
   logic [31:0]            wd_q, wd_d, rd_q, rd_d;
   logic [3:0]             ws_q, ws_d;
   logic [1:0]             br_q, br_d, rr_q, rr_d;
   prr_cfg_s               cfg_q, cfg_d;
   logic [31:0]            sta_q, sta_d, sto_q, sto_d;
   logic                   wr_go, cmd_wr, ud_wr;
   logic [3:0]             cmd_code;
   logic [31:0]            status_word;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < `PRR_BYTES; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready  = !w_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;
   assign wr_go         = aw_q && w_q && !bv_q;
   assign cmd_wr        = wr_go && (awa_q == `PRR_OFF_CMD) && ws_q[0];
   assign cmd_code      = wd_q[3:0];
   assign ud_wr         = wr_go && (awa_q == `PRR_OFF_USER);

   always_comb begin
      aw_d  = aw_q;
      w_d   = w_q;
      awa_d = awa_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      bv_d  = bv_q && !s_axi_bready;
      br_d  = br_q;
      rv_d  = rv_q && !s_axi_rready;
      rd_d  = rd_q;
      rr_d  = rr_q;
      cfg_d = cfg_q;
      sta_d = sta_q;
      sto_d = sto_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = `PRR_RESP_OKAY;
         unique case (awa_q)
            `PRR_OFF_CMD, `PRR_OFF_USER : ;
            `PRR_OFF_CFG   : cfg_d = prr_cfg_s'(merge(cfg_q, wd_q, ws_q));
            `PRR_OFF_START : sta_d = merge(sta_q, wd_q, ws_q);
            `PRR_OFF_STOP  : sto_d = merge(sto_q, wd_q, ws_q);
            default        : br_d = `PRR_RESP_SLVERR;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = `PRR_RESP_OKAY;
         unique case (s_axi_araddr)
            `PRR_OFF_CMD    : rd_d = '0;
            `PRR_OFF_CFG    : rd_d = cfg_q;
            `PRR_OFF_START  : rd_d = sta_q;
            `PRR_OFF_STOP   : rd_d = sto_q;
            `PRR_OFF_STATUS : rd_d = status_word;
            `PRR_OFF_ADDR   : rd_d = 32'(mem_addr);
            `PRR_OFF_USER   : rd_d = idx_bus.rdata.user;
            default : begin
               rd_d = '0;
               rr_d = `PRR_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         bv_q  <= 1'b0;
         rv_q  <= 1'b0;
         awa_q <= '0;
         wd_q  <= '0;
         ws_q  <= '0;
         br_q  <= '0;
         rd_q  <= '0;
         rr_q  <= '0;
         cfg_q <= '0;    // gain resets to 0 dB
         sta_q <= '0;
         sto_q <= '0;
      end else begin
         aw_q  <= aw_d;
         w_q   <= w_d;
         bv_q  <= bv_d;
         rv_q  <= rv_d;
         awa_q <= awa_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         br_q  <= br_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
         cfg_q <= cfg_d;
         sta_q <= sta_d;
         sto_q <= sto_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   prr_state_e             st_q, st_d;
   logic [`PRR_ADDR_W-1:0] ac_q, ac_d, sp_q, sp_d, st_addr_q, st_addr_d;
   logic [`PRR_BLK_W-1:0]  bc_q, bc_d, lim_q, lim_d, free_q, free_d;
   logic                   rec_q, rec_d, flag_q, flag_d, err_q, err_d;
   logic                   rrate_q, rrate_d, rwid_q, rwid_d;
   logic [1:0]             rom_rate_q, rom_rate_d;
   logic                   rom_mode, flex_mode, ph_ok, sel_zero;
   logic [`PRR_ADDR_W-1:0] ac_inc;
   logic                   blk_wrap;
   logic [`PRR_BLK_W-1:0]  bc_inc;
   prr_entry_s             ent;

   assign rom_mode  = (cfg_q.cmdset == `PRR_CS_ROM);
   assign flex_mode = (cfg_q.cmdset == `PRR_CS_FLEX);
   assign sel_zero  = (cfg_q.phrase == `PRR_PHRASE_ZERO);
   assign ph_ok     = rom_mode ? !sel_zero
                               : (cfg_q.phrase < `PRR_PH_LIMIT) && !(flex_mode && sel_zero);
   assign ac_inc    = ac_q + 1'b1;
   assign blk_wrap  = (ac_inc[BLK_SHIFT-1:0] == '0);
   assign bc_inc    = bc_q + 1'b1;
   assign ent       = idx_bus.rdata;

   always_comb begin
      st_d       = st_q;
      ac_d       = ac_q;
      sp_d       = sp_q;
      st_addr_d  = st_addr_q;
      bc_d       = bc_q;
      lim_d      = lim_q;
      free_d     = free_q;
      rec_d      = rec_q;
      flag_d     = flag_q;
      err_d      = err_q;
      rrate_d    = rrate_q;
      rwid_d     = rwid_q;
      rom_rate_d = rom_rate_q;
      idx_bus.idx     = cfg_q.phrase[`PRR_PH_W-1:0];
      idx_bus.we      = 1'b0;
      idx_bus.clr_all = 1'b0;
      idx_bus.wdata   = ent;
      unique case (st_q)
         ST_IDLE: begin
            if (ud_wr) begin
               idx_bus.we         = 1'b1;
               idx_bus.wdata.user = merge(ent.user, wd_q, ws_q);
            end
            if (cmd_wr) begin
               err_d = 1'b0;
               if (cmd_code == `PRR_CMD_ERASE) begin
                  st_d = sel_zero ? ST_CLR_ALL : ST_ER_ONE;
               end else if (cmd_code == `PRR_CMD_ADRLD) begin
                  idx_bus.we               = 1'b1;
                  idx_bus.wdata.start_addr = sta_q[`PRR_ADDR_W-1:0];
                  idx_bus.wdata.stop_addr  = sto_q[`PRR_ADDR_W-1:0];
               end else if (cmd_code == `PRR_CMD_START && ph_ok) begin
                  flag_d  = 1'b1;
                  rec_d   = !cfg_q.output_select_cmd_sel && !rom_mode;
                  rrate_d = rom_mode;
                  st_d    = rom_mode ? ST_ROM : ST_FETCH;
               end else if (cmd_code == `PRR_CMD_START) begin
                  err_d = 1'b1;
               end
            end
         end
         ST_FETCH: begin
            bc_d  = `PRR_BLK_ZERO;
            lim_d = cfg_q.blk_cnt;
            st_d  = ST_RUN;
            if (flex_mode && rec_q) begin
               // phrase zero holds the next free address and free block count
               idx_bus.idx = '0;
               ac_d        = ent.start_addr;
               st_addr_d   = ent.start_addr;
               free_d      = ent.blk_cnt;
               if (ent.blk_cnt == `PRR_BLK_ZERO || cfg_q.blk_cnt == `PRR_BLK_ZERO) begin
                  st_d = ST_SAVE;
               end
            end else begin
               ac_d      = ent.start_addr;
               st_addr_d = ent.start_addr;
               sp_d      = ent.stop_addr;
            end
         end
         ST_ROM: begin
            if (rom_idx_valid) begin
               ac_d       = rom_idx_start;
               sp_d       = rom_idx_stop;
               rom_rate_d = rom_idx_rate;
               rwid_d     = rom_idx_width;
               st_d       = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cmd_wr && cmd_code == `PRR_CMD_STOP) begin
               st_d = rec_q ? ST_SAVE : ST_IDLE;
               if (!rec_q) begin
                  flag_d = 1'b0;
               end
            end else if (flex_mode && rec_q) begin
               if (sample_tick) begin
                  ac_d = ac_inc;
                  if (blk_wrap) begin
                     bc_d = bc_inc;
                     if (bc_inc == lim_q || bc_inc == free_q) begin
                        st_d = ST_SAVE;
                     end
                  end
               end
            end else if (ac_q == sp_q) begin
               st_d   = rec_q ? ST_SAVE : ST_IDLE;
               flag_d = rec_q;
            end else if (sample_tick) begin
               ac_d = ac_inc;
            end
         end
         ST_SAVE: begin
            idx_bus.we              = 1'b1;
            idx_bus.wdata.stop_addr = ac_q;
            if (flex_mode) begin
               idx_bus.wdata.start_addr = st_addr_q;
               idx_bus.wdata.stop_blk   = bc_q;
               idx_bus.wdata.blk_cnt    = bc_q;
               st_d = ST_SAVE_CTL;
            end else begin
               st_d   = ST_IDLE;
               flag_d = 1'b0;
            end
         end
         ST_SAVE_CTL: begin
            idx_bus.idx              = '0;
            idx_bus.we               = 1'b1;
            idx_bus.wdata.start_addr = ac_q;
            idx_bus.wdata.blk_cnt    = ent.blk_cnt - bc_q;
            st_d   = ST_IDLE;
            flag_d = 1'b0;
         end
         ST_CLR_ALL: begin
            idx_bus.clr_all = 1'b1;
            st_d = ST_INIT_CTL;
         end
         ST_INIT_CTL: begin
            idx_bus.idx           = '0;
            idx_bus.we            = 1'b1;
            idx_bus.wdata         = '0;
            idx_bus.wdata.blk_cnt = `PRR_TOTAL_BLKS;
            st_d = ST_IDLE;
         end
         ST_ER_ONE: begin
            idx_bus.we    = 1'b1;
            idx_bus.wdata = '0;
            free_d = ent.blk_cnt;
            st_d   = ST_ER_CTL;
         end
         ST_ER_CTL: begin
            idx_bus.idx           = '0;
            idx_bus.we            = 1'b1;
            idx_bus.wdata.blk_cnt = ent.blk_cnt + free_q;
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q       <= ST_IDLE;
         ac_q       <= '0;
         sp_q       <= '0;
         st_addr_q  <= '0;
         bc_q       <= '0;
         lim_q      <= '0;
         free_q     <= '0;
         rec_q      <= 1'b0;
         flag_q     <= 1'b0;
         err_q      <= 1'b0;
         rrate_q    <= 1'b0;
         rwid_q     <= 1'b0;
         rom_rate_q <= '0;
      end else begin
         st_q       <= st_d;
         ac_q       <= ac_d;
         sp_q       <= sp_d;
         st_addr_q  <= st_addr_d;
         bc_q       <= bc_d;
         lim_q      <= lim_d;
         free_q     <= free_d;
         rec_q      <= rec_d;
         flag_q     <= flag_d;
         err_q      <= err_d;
         rrate_q    <= rrate_d;
         rwid_q     <= rwid_d;
         rom_rate_q <= rom_rate_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign status_word           = {29'h0, err_q, (st_q != ST_IDLE), flag_q};
   assign mem_addr              = ac_q;
   assign mem_record            = (st_q == ST_RUN) && rec_q;
   assign mem_output_select_cmd              = (st_q == ST_RUN) && !rec_q;
   assign active_operation_flag = flag_q;
   assign rom_idx_req           = (st_q == ST_ROM);
   assign rom_idx_phrase        = cfg_q.phrase;
   assign sample_width          = rrate_q ? rwid_q : cfg_q.width;
   assign rate_sel              = rrate_q ? rom_rate_q : cfg_q.rate;
   assign activation_threshold  = (flag_q && !rec_q) ? 2'h0 : cfg_q.thresh;
   assign gain_shift            = (cfg_q.gain == `PRR_GAIN_M12) ? `PRR_SHIFT_12DB
                                : (cfg_q.gain == `PRR_GAIN_M6)  ? `PRR_SHIFT_6DB
                                : `PRR_SHIFT_0DB;

endmodule : prr_sequencer

//--- prr_consts.svh
`ifndef PRR_CONSTS_SVH
`define PRR_CONSTS_SVH

`define PRR_ADDR_W      16
`define PRR_PH_W        6
`define PRR_NUM_PH      64
`define PRR_BLK_W       8
`define PRR_USER_W      32
`define PRR_TOTAL_BLKS  8'hff
`define PRR_PHRASE_ZERO 8'h00
`define PRR_PH_LIMIT    8'h40
`define PRR_BLK_ZERO    8'h00

// register byte offsets
`define PRR_OFF_CMD     8'h00
`define PRR_OFF_CFG     8'h04
`define PRR_OFF_START   8'h08
`define PRR_OFF_STOP    8'h0c
`define PRR_OFF_STATUS  8'h10
`define PRR_OFF_ADDR    8'h14
`define PRR_OFF_USER    8'h18

// command codes written to the command register
`define PRR_CMD_ERASE   4'h1
`define PRR_CMD_START   4'h2
`define PRR_CMD_STOP    4'h3
`define PRR_CMD_ADRLD   4'h4

// command set codes
`define PRR_CS_FLEX     2'h0
`define PRR_CS_ROM      2'h1
`define PRR_CS_DIRECT   2'h2

// gain level codes and shifts
`define PRR_GAIN_M6     2'h2
`define PRR_GAIN_M12    2'h3
`define PRR_SHIFT_0DB   2'h0
`define PRR_SHIFT_6DB   2'h1
`define PRR_SHIFT_12DB  2'h2

`define PRR_RESP_OKAY   2'h0
`define PRR_RESP_SLVERR 2'h2
`define PRR_BYTES       4

`endif

//--- prr_pkg.sv
`include "prr_consts.svh"

package prr_pkg;

   typedef struct packed {
      logic [`PRR_ADDR_W-1:0] start_addr;
      logic [`PRR_ADDR_W-1:0] stop_addr;
      logic [`PRR_BLK_W-1:0]  stop_blk;
      logic [`PRR_BLK_W-1:0]  blk_cnt;
      logic [`PRR_USER_W-1:0] user;
   } prr_entry_s;

   typedef struct packed {
      logic [7:0] blk_cnt;
      logic [5:0] rsvd;
      logic       output_select_cmd_sel;
      logic [1:0] gain;
      logic [1:0] thresh;
      logic       width;
      logic [1:0] rate;
      logic [1:0] cmdset;
      logic [7:0] phrase;
   } prr_cfg_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_FETCH, ST_ROM, ST_RUN, ST_SAVE, ST_SAVE_CTL,
      ST_CLR_ALL, ST_INIT_CTL, ST_ER_ONE, ST_ER_CTL
   } prr_state_e;

endpackage : prr_pkg

//--- prr_idx_if.sv
`timescale 1ns/1ps
`include "prr_consts.svh"

interface prr_idx_if;
   import prr_pkg::*;
   logic [`PRR_PH_W-1:0] idx;
   logic                 we;
   logic                 clr_all;
   prr_entry_s           wdata;
   prr_entry_s           rdata;

   modport master (output idx, output we, output clr_all, output wdata, input rdata);
   modport store  (input idx, input we, input clr_all, input wdata, output rdata);
endinterface : prr_idx_if

//--- prr_index_store.sv
`timescale 1ns/1ps
`include "prr_consts.svh"

module prr_index_store
   import prr_pkg::*;
#(
   parameter int NUM_PH = `PRR_NUM_PH
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   prr_idx_if.store  bus
);

   prr_entry_s ent_q [NUM_PH];
   prr_entry_s ent_d [NUM_PH];

   // per-phrase channel index entries; clear-all zeroes every entry at once
   for (genvar i = 0; i < NUM_PH; i++) begin : g_ent
      always_comb begin
         ent_d[i] = ent_q[i];
         if (bus.clr_all) begin
            ent_d[i] = '0;
         end else if (bus.we && (bus.idx == `PRR_PH_W'(i))) begin
            ent_d[i] = bus.wdata;
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            ent_q[i] <= '0;
         end else begin
            ent_q[i] <= ent_d[i];
         end
      end
   end

   assign bus.rdata = ent_q[bus.idx];

endmodule : prr_index_store

//--- prr_seq_monitor.sv
`timescale 1ns/1ps
module prr_seq_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sample_tick,
   input wire logic [15:0] mem_addr,
   input wire logic        mem_output_select_cmd,
   input wire logic        mem_record,
   input wire logic        active_operation_flag,
   input wire logic [1:0]  activation_threshold,
   input wire logic        rom_idx_req,
   input wire logic        rom_idx_valid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_output_select_cmd_end;
      !mem_output_select_cmd ##[0:1] !active_operation_flag;
   endsequence
   a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data withdrawn");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
   a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_run_flag: assert property (mem_output_select_cmd || mem_record |-> active_operation_flag)
      else $error("run without active flag");
   a_thresh_off: assert property (mem_output_select_cmd |-> activation_threshold == 2'h0)
      else $error("threshold live in playback");
   a_addr_hold: assert property (mem_output_select_cmd && !sample_tick ##1 mem_output_select_cmd |-> $stable(mem_addr))
      else $error("address moved without tick");
   a_output_select_cmd_stop: assert property ($fell(mem_output_select_cmd) |-> s_output_select_cmd_end)
      else $error("flag stays after playback");
   a_rom_taken: assert property (rom_idx_req && rom_idx_valid |=> !rom_idx_req)
      else $error("index request held after answer");
   a_rom_first: assert property (rom_idx_req |-> !mem_output_select_cmd && active_operation_flag)
      else $error("playback before index fetch");
endmodule : prr_seq_monitor

bind prr_sequencer prr_seq_monitor prr_seq_monitor_i (.*);

//--- prr_rom_model.sv
`timescale 1ns/1ps
module prr_rom_model (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        rom_idx_req,
   input wire logic [7:0]  rom_idx_phrase,
   output logic            rom_idx_valid,
   output logic [15:0]     rom_idx_start,
   output logic [15:0]     rom_idx_stop,
   output logic [1:0]      rom_idx_rate,
   output logic            rom_idx_width
);
   logic [1:0]  wait_q;
   logic [15:0] base;
   always_ff @(posedge aclk) begin
      wait_q <= (!aresetn || !rom_idx_req || rom_idx_valid) ? 2'h0 : wait_q + 2'h1;
   end
   // odd phrases answer two cycles late
   assign rom_idx_valid = rom_idx_req && (wait_q >= {rom_idx_phrase[0], 1'b0});
   assign base = {rom_idx_phrase, 8'h00};
   // lines outside an answer show the inverse, never a stale value
   assign rom_idx_start = rom_idx_valid ? base : ~base;
   assign rom_idx_stop = rom_idx_valid ? base + 16'(rom_idx_phrase[2:0]) + 16'h1 : ~base;
   assign rom_idx_rate = rom_idx_valid ? rom_idx_phrase[1:0] : ~rom_idx_phrase[1:0];
   assign rom_idx_width = rom_idx_valid ? rom_idx_phrase[2] : ~rom_idx_phrase[2];
endmodule : prr_rom_model

//--- phrase_record_playback_sequencer_test.sv
`timescale 1ns/1ps
`include "prr_consts.svh"
module phrase_record_playback_sequencer_test;
   import prr_pkg::*;
   logic        aclk, aresetn, sample_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, mem_record, mem_output_select_cmd, active_operation_flag;
   logic        sample_width, rom_idx_req, rom_idx_valid, rom_idx_width;
   logic [1:0]  s_axi_bresp, s_axi_rresp, gain_shift, rate_sel, activation_threshold, rom_idx_rate, r;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rom_idx_phrase, p;
   logic [15:0] mem_addr, rom_idx_start, rom_idx_stop, rs, ts, s, m;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   int          miscompares, check_count;

   prr_sequencer #(.BLK_SHIFT(8)) prr_sequencer_i (.*);
   prr_rom_model prr_rom_model_i (.*);

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   // one block, threshold 3, rate 1, width 0
   function automatic logic [31:0] cfg(input logic [7:0] ph, input logic [1:0] cs, input logic pl,
                                       input logic [1:0] g);
      return {8'h01, 6'h00, pl, g, 2'h3, 1'b0, 2'h1, cs, ph};
   endfunction : cfg
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic go;
      wr(`PRR_OFF_CMD, 32'(`PRR_CMD_START));
      @(posedge aclk);
      chk("flag_set", 1, active_operation_flag);
   endtask : go
   // poll status until neither active nor busy
   task automatic idle;
      int n;
      n = 0;
      d = '1;
      while (d[1:0] !== 2'h0 && n < 3000) begin
         rd(`PRR_OFF_STATUS);
         n++;
      end
      chk("idle", 0, d[1:0]);
   endtask : idle
   task automatic erase(input logic [7:0] ph);
      wr(`PRR_OFF_CFG, cfg(ph, `PRR_CS_FLEX, 1'b0, 2'h0));
      wr(`PRR_OFF_CMD, 32'(`PRR_CMD_ERASE));
      idle;
   endtask : erase
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      ts <= lfsr(ts);
      sample_tick <= ts[0];
   end
   // the tests need about 2k cycles
   initial begin
      #300000;
      miscompares++;
      wrap_up;
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {sample_tick, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      rs = 16'h6278;
      ts = 16'h6278;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("gain_rst", 0, gain_shift);
      for (int g = 0; g < 4; g++) begin
         wr(`PRR_OFF_CFG, cfg(8'h01, `PRR_CS_FLEX, 1'b1, 2'(g)));
         @(posedge aclk);
         chk("gain", (g < 2) ? 0 : g - 1, gain_shift);
      end
      $display("gain test done");
      for (int ph = 0; ph < 2; ph++) begin
         rs = lfsr(rs);
         wr(`PRR_OFF_CFG, cfg(8'h09, `PRR_CS_FLEX, 1'b0, 2'h0));
         wr(`PRR_OFF_USER, {rs, ~rs});
         rd(`PRR_OFF_USER);
         chk("user_wr", {rs, ~rs}, d);
         erase(ph ? 8'h09 : 8'h00);
         wr(`PRR_OFF_CFG, cfg(8'h09, `PRR_CS_FLEX, 1'b0, 2'h0));
         rd(`PRR_OFF_USER);
         chk("user", 0, d);
      end
      rd(8'h40);
      chk("resp", `PRR_RESP_SLVERR, r);
      wr(8'h40, '0);
      chk("bresp", `PRR_RESP_SLVERR, r);
      $display("erase test done");
      for (int i = 0; i < 3; i++) begin
         rs = lfsr(rs);
         p = {2'h0, rs[5:0]};
         s = {rs[15:4], 4'h0};
         wr(`PRR_OFF_CFG, cfg(p, `PRR_CS_DIRECT, 1'b1, 2'h0));
         wr(`PRR_OFF_START, 32'(s));
         wr(`PRR_OFF_STOP, 32'(s + 16'(rs[3:0]) + 16'h3));
         wr(`PRR_OFF_CMD, 32'(`PRR_CMD_ADRLD));
         go;
         idle;
         chk("output_select_cmd_end", 16'(s + 16'(rs[3:0]) + 16'h3), mem_addr);
      end
      wr(`PRR_OFF_CFG, cfg(p, `PRR_CS_DIRECT, 1'b0, 2'h0));
      wr(`PRR_OFF_STOP, 32'(s + 16'h0100));
      wr(`PRR_OFF_CMD, 32'(`PRR_CMD_ADRLD));
      go;
      repeat (30) @(posedge aclk);
      chk("thresh_rec", 2'h3, activation_threshold);
      wr(`PRR_OFF_CMD, 32'(`PRR_CMD_STOP));
      idle;
      rd(`PRR_OFF_ADDR);
      m = d[15:0] - s;
      chk("mid_stop", 1, m != 0 && m < 16'h0100);
      wr(`PRR_OFF_CFG, cfg(p, `PRR_CS_DIRECT, 1'b1, 2'h0));
      go;
      idle;
      chk("new_stop", 16'(m + s), mem_addr);
      $display("direct test done");
      for (int i = 0; i < 2; i++) begin
         rs = lfsr(rs);
         p = {rs[7:2], 1'b1, 1'(i)};
         wr(`PRR_OFF_CFG, cfg(p, `PRR_CS_ROM, 1'b1, 2'h0));
         go;
         idle;
         chk("rom_rate", p[1:0], rate_sel);
         chk("rom_width", p[2], sample_width);
         chk("rom_end", {p, 8'h00} + 16'(p[2:0]) + 16'h1, mem_addr);
      end
      $display("rom test done");
      erase(8'h00);
      wr(`PRR_OFF_CFG, cfg(8'h01, `PRR_CS_FLEX, 1'b0, 2'h0));
      go;
      idle;
      wr(`PRR_OFF_CFG, cfg(8'h01, `PRR_CS_FLEX, 1'b1, 2'h0));
      go;
      idle;
      chk("flex_output_select_cmd", 0, mem_output_select_cmd);
      chk("flex_end", 16'h0100, mem_addr);
      wr(`PRR_OFF_CFG, cfg(8'h00, `PRR_CS_FLEX, 1'b1, 2'h0));
      wr(`PRR_OFF_CMD, 32'(`PRR_CMD_START));
      rd(`PRR_OFF_STATUS);
      chk("refused", 1, d[2]);
      $display("flex test done");
      wrap_up;
   end
endmodule : phrase_record_playback_sequencer_test
